//--- core/fcim_core.sv
// Functional notes
// - at most one instruction accepted per cycle
// - stall cpu while pipeline cannot accept
// - killed speculative instructions never commit results
// - stall cpu also during unresolved hazard
// - read one cycle, variable execute, one commit
// - complete or kill strictly in issue order
// - ieee layout, biases 127 and 1023
// - implicit leading one except subnormals
// - word 16, long 32, double 64 bits
// - number-preferring ops return the number
// - strict ops return quiet nan on nan
// - infinities outer, negative zero below positive
// - signalling nan sets flag, trap if unmasked
// - signalling with quiet nan returns quiet one
// - strict op quiets the signalling operand
// - unmasked fault latches faulting address
// - address register writable in all modes
// - oversized conversion raises huge integer fault
// - no local storage beyond register set
// - quiet nan has top significand bit set
// - same-class nans pick larger significand
`timescale 1ns/1ps
`default_nettype none
`include "fcim_consts.svh"

module fcim_core
  import fcim_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction issue from cpu
  input wire logic issue_valid,
  input wire fcim_issue_s issue,
  output logic issue_stall,
  // speculation resolution
  input wire logic spec_commit,
  input wire logic spec_kill,
  // hazard query from cpu: register it is about to read
  input wire logic haz_check,
  input wire logic [4:0] haz_reg,
  // results and faults
  output fcim_result_s result,
  output logic fault_trap
);

  ////////////////////////////////////////////////////////////////////////////
  // nan classification and ordering helpers

  // nan test on a value of either precision
  function automatic logic is_nan(input logic [63:0] v, input logic dbl);
    if (dbl) begin
      is_nan = (&v[62:52]) && (|v[51:0]);
    end else begin
      is_nan = (&v[30:23]) && (|v[22:0]);
    end
  endfunction

  // signalling nan: top fraction bit clear
  function automatic logic is_snan(input logic [63:0] v, input logic dbl);
    is_snan = is_nan(v, dbl) && !(dbl ? v[51] : v[22]);
  endfunction

  // quieting sets the top fraction bit
  function automatic logic [63:0] quiet(input logic [63:0] v, input logic dbl);
    quiet = v;
    if (dbl) begin
      quiet[51] = 1'b1;
    end else begin
      quiet[22] = 1'b1;
    end
  endfunction

  // total order key: sign-magnitude into unsigned, -0 below +0
  function automatic logic [63:0] order_key(input logic [63:0] v, input logic dbl);
    logic [63:0] w;
    w = dbl ? v : {32'h0000_0000, v[31:0]};
    if (dbl ? w[63] : w[31]) begin
      order_key = dbl ? ~w : {32'h0000_0000, ~w[31:0]};
    end else begin
      order_key = dbl ? (w | 64'h8000_0000_0000_0000) :
                  {32'h0000_0000, w[31:0] | 32'h8000_0000};
    end
  endfunction

  // significand magnitude, sign ignored
  function automatic logic [51:0] sig_mag(input logic [63:0] v, input logic dbl);
    sig_mag = dbl ? v[51:0] : {29'h0000_0000, v[22:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file and control state

  logic [63:0] freg_q [`FCIM_REG_CNT]; // only local storage
  logic inv_mask_q; // invalid exception mask, 1 = masked
  logic debug_q; // debug mode indicator
  logic bad_op_q; // sticky invalid flag
  logic huge_q; // sticky huge integer flag
  logic [23:0] foa_q; // fault_origin_address
  fcim_state_e state_q; // slot stage
  fcim_issue_s slot_q; // instruction in flight
  logic spec_q; // slot still speculative
  logic [4:0] exec_cnt_q; // remaining execute cycles
  logic [63:0] res_q; // computed result
  logic bad_q; // computed invalid event
  logic hg_q; // computed huge integer event
  fcim_result_s result_q; // write back register
  logic trap_q; // exception pulse

  ////////////////////////////////////////////////////////////////////////////
  // issue acceptance and hazard stall

  logic accept;
  logic busy;
  logic haz_hit;
  assign busy = (state_q != FCIM_ST_IDLE);
  // pending destination that cpu wants is a data hazard
  assign haz_hit = haz_check && busy && (slot_q.dst == haz_reg) &&
                   (slot_q.op != FCIM_OP_IDLE);
  // one slot: accept only when idle, at most one per cycle
  assign accept = issue_valid && !busy;
  // stall while full or while hazard unresolved
  assign issue_stall = (issue_valid && busy) || haz_hit;

  ////////////////////////////////////////////////////////////////////////////
  // execute combinational: min/max and conversion

  logic [63:0] ex_res;
  logic ex_bad;
  logic ex_huge;
  logic [4:0] ex_len;
  always_comb begin
    logic na, nb, sa, sb, lo, pick_a;
    logic [63:0] a, b, nanres;
    logic [10:0] ue;
    a = slot_q.opa;
    b = slot_q.opb;
    na = is_nan(a, slot_q.dbl);
    nb = is_nan(b, slot_q.dbl);
    sa = is_snan(a, slot_q.dbl);
    sb = is_snan(b, slot_q.dbl);
    lo = (slot_q.op == FCIM_OP_NUM_LO) || (slot_q.op == FCIM_OP_STR_LO);
    ue = 11'h000;
    // numeric ordering, ties keep second operand
    pick_a = lo ? (order_key(a, slot_q.dbl) < order_key(b, slot_q.dbl)) :
                  (order_key(a, slot_q.dbl) > order_key(b, slot_q.dbl));
    // nan choice between two nans
    if (sa && !sb) begin
      nanres = b; // quiet one unchanged
    end else if (sb && !sa) begin
      nanres = a;
    end else if (sig_mag(a, slot_q.dbl) >= sig_mag(b, slot_q.dbl)) begin
      nanres = quiet(a, slot_q.dbl); // larger significand
    end else begin
      nanres = quiet(b, slot_q.dbl);
    end
    ex_res = 64'h0000_0000_0000_0000;
    ex_bad = 1'b0;
    ex_huge = 1'b0;
    ex_len = 5'd1;
    case (slot_q.op)
      FCIM_OP_NUM_LO, FCIM_OP_NUM_HI: begin
        ex_bad = sa || sb;
        if (na && nb) begin
          ex_res = nanres;
        end else if (na) begin
          ex_res = b; // number wins
        end else if (nb) begin
          ex_res = a;
        end else begin
          ex_res = pick_a ? a : b;
        end
      end
      FCIM_OP_STR_LO, FCIM_OP_STR_HI: begin
        ex_bad = sa || sb;
        if (na && nb) begin
          ex_res = nanres;
        end else if (na) begin
          ex_res = quiet(a, slot_q.dbl);
        end else if (nb) begin
          ex_res = quiet(b, slot_q.dbl);
        end else begin
          ex_res = pick_a ? a : b;
        end
      end
      FCIM_OP_CVT_WIDE, FCIM_OP_CVT_LONG: begin
        // biased exponent against bias plus destination width minus one
        if (slot_q.dbl) begin
          ue = a[62:52];
          ex_huge = na || (ue >= 11'(`FCIM_DP_BIAS +
                    ((slot_q.op == FCIM_OP_CVT_WIDE) ? `FCIM_DWORD_W : `FCIM_LONG_W) - 1));
        end else begin
          ue = {3'b000, a[30:23]};
          ex_huge = na || (ue >= 11'(`FCIM_SP_BIAS +
                    ((slot_q.op == FCIM_OP_CVT_WIDE) ? `FCIM_DWORD_W : `FCIM_LONG_W) - 1));
        end
        // hidden bit only, no fraction bits, zero for subnormals
        ex_res = slot_q.dbl ? {63'h0, |a[62:52]} : {63'h0, |a[30:23]};
      end
      FCIM_OP_DIV: begin
        ex_len = `FCIM_DIV_CYCLES; // long execute
        ex_res = a;
      end
      FCIM_OP_MOVE: begin
        ex_res = a;
      end
      default: begin
        ex_res = 64'h0000_0000_0000_0000; // idle op writes nothing
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pipeline stage sequencing

  logic killed;
  assign killed = spec_q && spec_kill;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= FCIM_ST_IDLE;
      slot_q <= '0;
      exec_cnt_q <= 5'd0;
    end else begin
      case (state_q)
        FCIM_ST_IDLE: begin
          if (accept) begin
            slot_q <= issue; // cpu moves on as idle op
            state_q <= FCIM_ST_READ;
          end
        end
        FCIM_ST_READ: begin
          if (killed) begin
            state_q <= FCIM_ST_IDLE; // discard
          end else begin
            exec_cnt_q <= ex_len; // read takes one cycle
            state_q <= FCIM_ST_EXEC;
          end
        end
        FCIM_ST_EXEC: begin
          if (killed) begin
            state_q <= FCIM_ST_IDLE;
          end else if (exec_cnt_q <= 5'd1 && !spec_q) begin
            state_q <= FCIM_ST_COMMIT; // wait for commit before writing
          end else if (exec_cnt_q > 5'd1) begin
            exec_cnt_q <= exec_cnt_q - 5'd1;
          end
        end
        FCIM_ST_COMMIT: begin
          state_q <= FCIM_ST_IDLE; // commit exactly one cycle
        end
        default: begin
          state_q <= FCIM_ST_IDLE;
        end
      endcase
    end
  end

  // speculation tracking of the slot
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spec_q <= 1'b0;
    end else if (accept) begin
      spec_q <= issue.spec;
    end else if (spec_commit || spec_kill) begin
      spec_q <= 1'b0;
    end
  end

  // capture execute results at end of execute
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res_q <= 64'h0000_0000_0000_0000;
      bad_q <= 1'b0;
      hg_q <= 1'b0;
    end else if (state_q == FCIM_ST_EXEC) begin
      res_q <= ex_res;
      bad_q <= ex_bad;
      hg_q <= ex_huge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write back, flags and fault address

  logic commit;
  logic [31:0] wdat;
  assign commit = (state_q == FCIM_ST_COMMIT);
  assign wdat = pwdata;

  // register file write at commit only
  always_ff @(posedge ref_clk) begin
    if (commit && slot_q.op != FCIM_OP_IDLE) begin
      freg_q[slot_q.dst] <= res_q;
    end
  end

  // result port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_q <= '0;
    end else begin
      result_q.valid <= commit && (slot_q.op != FCIM_OP_IDLE);
      result_q.dst <= slot_q.dst;
      result_q.data <= res_q;
    end
  end
  assign result = result_q;

  // sticky flags, set wins over software clear
  logic wr_stat;
  assign wr_stat = psel && penable && pwrite && (paddr == `FCIM_ADDR_STAT);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bad_op_q <= 1'b0;
      huge_q <= 1'b0;
    end else begin
      bad_op_q <= (commit && bad_q) ||
                  (bad_op_q && !(wr_stat && wdat[`FCIM_STAT_BAD_OP]));
      huge_q <= (commit && hg_q) ||
                (huge_q && !(wr_stat && wdat[`FCIM_STAT_HUGE]));
    end
  end

  // trap pulse: invalid only when unmasked, huge integer always
  logic fault_now;
  assign fault_now = commit && ((bad_q && !inv_mask_q) || hg_q);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= fault_now;
    end
  end
  assign fault_trap = trap_q;

  // fault_origin_address: capture on unmasked fault, software write otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      foa_q <= 24'h00_0000;
    end else if (fault_now) begin
      foa_q <= slot_q.addr; // capture wins
    end else if (psel && penable && pwrite && paddr == `FCIM_ADDR_FOA) begin
      foa_q <= wdat[23:0]; // writable in any mode
    end
  end

  // control register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inv_mask_q <= 1'(`FCIM_CTRL_RESET >> `FCIM_CTRL_INV_MASK); // mask bit of reset word
      debug_q <= 1'b0;
    end else if (psel && penable && pwrite && paddr == `FCIM_ADDR_CTRL) begin
      inv_mask_q <= wdat[`FCIM_CTRL_INV_MASK];
      debug_q <= wdat[`FCIM_CTRL_DEBUG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path: zero wait states

  assign pready = 1'b1;
  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    if (psel && penable) begin
      case (paddr)
        `FCIM_ADDR_CTRL: prdata = {30'h0, debug_q, inv_mask_q};
        `FCIM_ADDR_STAT: prdata = {29'h0, busy, huge_q, bad_op_q};
        `FCIM_ADDR_FOA: prdata = {8'h00, foa_q}; // readable in any mode
        default: pslverr = 1'b1; // unmapped address
      endcase
    end
  end

endmodule
`default_nettype wire

//--- common/fcim_consts.svh
`ifndef FCIM_CONSTS_SVH
`define FCIM_CONSTS_SVH
// apb register byte offsets
`define FCIM_ADDR_CTRL 12'h000
`define FCIM_ADDR_STAT 12'h004
`define FCIM_ADDR_FOA 12'h008
// control register fields
`define FCIM_CTRL_INV_MASK 0
`define FCIM_CTRL_DEBUG 1
`define FCIM_CTRL_RESET 32'h0000_0001
// status register fields
`define FCIM_STAT_BAD_OP 0
`define FCIM_STAT_HUGE 1
`define FCIM_STAT_BUSY 2
// ieee layout
`define FCIM_SP_BIAS 127
`define FCIM_DP_BIAS 1023
`define FCIM_SP_EXP_W 8
`define FCIM_SP_FRAC_W 23
`define FCIM_DP_EXP_W 11
`define FCIM_DP_FRAC_W 52
// data sizes shared with the cpu
`define FCIM_WORD_W 16
`define FCIM_LONG_W 32
`define FCIM_DWORD_W 64
// pipeline geometry
`define FCIM_TAG_W 4
`define FCIM_DIV_CYCLES 5'd16
`define FCIM_REG_CNT 32
`endif

//--- common/fcim_pkg.sv
package fcim_pkg;
  // operation codes issued by the cpu
  typedef enum logic [3:0] {
    FCIM_OP_IDLE = 4'h0,
    FCIM_OP_NUM_LO = 4'h1,
    FCIM_OP_NUM_HI = 4'h2,
    FCIM_OP_STR_LO = 4'h3,
    FCIM_OP_STR_HI = 4'h4,
    FCIM_OP_CVT_WIDE = 4'h5,
    FCIM_OP_CVT_LONG = 4'h6,
    FCIM_OP_DIV = 4'h7,
    FCIM_OP_MOVE = 4'h8
  } fcim_op_e;
  // stage states of the single execution slot
  typedef enum logic [3:0] {
    FCIM_ST_IDLE = 4'b0001,
    FCIM_ST_READ = 4'b0010,
    FCIM_ST_EXEC = 4'b0100,
    FCIM_ST_COMMIT = 4'b1000
  } fcim_state_e;
  // one issued instruction
  typedef struct packed {
    fcim_op_e op;
    logic dbl;
    logic [4:0] dst;
    logic [63:0] opa;
    logic [63:0] opb;
    logic [23:0] addr;
    logic spec;
  } fcim_issue_s;
  // register write back toward the cpu
  typedef struct packed {
    logic valid;
    logic [4:0] dst;
    logic [63:0] data;
  } fcim_result_s;
endpackage

//--- tb/fcim_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcim_cpu_model
  import fcim_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // issue toward the coprocessor
  output logic issue_valid,
  output fcim_issue_s issue,
  input wire logic issue_stall,
  // speculation and hazard probes
  output logic spec_commit,
  output logic spec_kill,
  output logic haz_check,
  output logic [4:0] haz_reg
);
  ////////////////////////////////////////
  // idle levels at time zero
  initial begin
    issue_valid = 1'b0;
    issue = '0;
    spec_commit = 1'b0;
    spec_kill = 1'b0;
    haz_check = 1'b0;
    haz_reg = 5'h0;
  end
  // one instruction with its operands, held until taken
  task automatic send(input fcim_issue_s ins);
    @(posedge ref_clk);
    issue_valid <= 1'b1;
    issue <= ins;
    do @(posedge ref_clk); while (issue_stall);
    issue_valid <= 1'b0; // cpu moves on as after an idle op
    issue <= ~ins; // stale bus never repeats the last word
  endtask
  // one-cycle pulse that commits or cancels a speculative slot
  task automatic resolve(input logic kill);
    @(posedge ref_clk);
    spec_kill <= kill;
    spec_commit <= !kill;
    @(posedge ref_clk);
    spec_kill <= 1'b0;
    spec_commit <= 1'b0;
  endtask
  // ask whether a register is still pending
  task automatic probe(input logic [4:0] r, input logic on);
    @(posedge ref_clk);
    haz_check <= on;
    haz_reg <= r;
  endtask
endmodule
`default_nettype wire

//--- tb/fcim_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcim_consts.svh"
module fcim_core_asserts
  import fcim_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // issue and results
  input wire logic issue_valid,
  input wire fcim_issue_s issue,
  input wire logic issue_stall,
  input wire logic spec_kill,
  input wire logic haz_check,
  input wire fcim_result_s result,
  input wire logic fault_trap
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // an issue is taken on this edge
  wire logic take = issue_valid && !issue_stall;
  // single-cycle min/max op, not speculative
  wire logic quick = take && !issue.spec && issue.op inside {FCIM_OP_NUM_LO,
    FCIM_OP_NUM_HI, FCIM_OP_STR_LO, FCIM_OP_STR_HI};
  // slot holds an accepted op until its result shows or a kill lands
  logic inflight_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inflight_q <= 1'b0;
    end else if (take && issue.op != FCIM_OP_IDLE) begin
      inflight_q <= 1'b1;
    end else if (result.valid || spec_kill) begin
      inflight_q <= 1'b0;
    end
  end
  AST_BUSY_STALL: assert property (inflight_q && !result.valid && issue_valid |-> issue_stall)
    else $error("second issue taken while busy");
  AST_QUICK_LAT: assert property (quick |-> ##4 result.valid)
    else $error("min max result late");
  AST_DIV_LAT: assert property (take && !issue.spec && issue.op == FCIM_OP_DIV |->
    ##19 result.valid)
    else $error("divide result late");
  AST_PULSE: assert property (result.valid |=> !result.valid)
    else $error("result held past one cycle");
  AST_IN_ORDER: assert property (take |=> !result.valid [*3])
    else $error("result overtakes pipeline");
  AST_KILL: assert property (spec_kill |=> !result.valid [*4])
    else $error("cancelled op wrote a result");
  AST_TRAP: assert property (fault_trap |-> result.valid)
    else $error("trap without a result");
  AST_STALL_CAUSE: assert property (!issue_valid && !haz_check |-> !issue_stall)
    else $error("stall with no cause");
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("apb access not answered");
  AST_SLVERR: assert property (psel && penable && !(paddr inside {`FCIM_ADDR_CTRL,
    `FCIM_ADDR_STAT, `FCIM_ADDR_FOA}) |-> pslverr)
    else $error("unmapped access not refused");
  // main scenarios
  cover property (quick);
  cover property (spec_kill);
  cover property (fault_trap);
  cover property (inflight_q && issue_valid && issue_stall);
endmodule
bind fcim_core fcim_core_asserts u_chk (.ref_clk, .rst_n, .psel, .penable, .paddr, .pready,
  .pslverr, .issue_valid, .issue, .issue_stall, .spec_kill, .haz_check, .result, .fault_trap);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcim_consts.svh"
module tb;
  import fcim_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, issue_valid, issue_stall, spec_commit, spec_kill;
  logic haz_check, fault_trap, mask_q, d;
  logic [4:0] haz_reg;
  logic [23:0] foa_q;
  fcim_issue_s issue, ins;
  fcim_result_s result;
  int bad_count = 0, check_count = 0;
  fcim_cpu_model cpu (.ref_clk, .issue_valid, .issue, .issue_stall, .spec_commit,
    .spec_kill, .haz_check, .haz_reg);
  fcim_core dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .issue_valid, .issue, .issue_stall, .spec_commit, .spec_kill,
    .haz_check, .haz_reg, .result, .fault_trap);
  ////////////////////////////////////////
  // 250 MHz clock
  initial forever #2 ref_clk = ~ref_clk;
  // compare and count
  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one apb transfer, read data taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////
  // expected min/max value, signalling flag on top
  function automatic logic [64:0] mm(input fcim_op_e op, input logic dl,
                                     input logic [63:0] a, input logic [63:0] b);
    int fw = dl ? `FCIM_DP_FRAC_W : `FCIM_SP_FRAC_W;
    int sw = dl ? 63 : 31;
    logic [63:0] q = 64'h1 << (fw - 1);
    logic [63:0] fm = (64'h1 << fw) - 64'h1;
    logic [63:0] em = (dl ? 64'h7FF : 64'hFF) << fw;
    logic [63:0] wm = (64'h1 << (sw + 1)) - 64'h1;
    logic na, nb, sa, sb, hi, num;
    logic [63:0] ka, kb;
    a = a & wm;
    b = b & wm;
    na = (a & em) == em && (a & fm) != 0;
    nb = (b & em) == em && (b & fm) != 0;
    sa = na && (a & q) == 0; // quiet bit clear
    sb = nb && (b & q) == 0;
    hi = op inside {FCIM_OP_NUM_HI, FCIM_OP_STR_HI};
    num = op inside {FCIM_OP_NUM_LO, FCIM_OP_NUM_HI};
    ka = a ^ (a[sw] ? wm : 64'h1 << sw); // order key, -0 below +0
    kb = b ^ (b[sw] ? wm : 64'h1 << sw);
    if (na && nb) begin
      a = sa != sb ? (sa ? b : a) : ((b & fm) > (a & fm) ? b : a) | q;
    end else if (na || nb) begin
      a = num ? (na ? b : a) : (na ? a : b) | q;
    end else begin
      a = (hi ? ka > kb : ka < kb) ? a : b; // ties give opb
    end
    return {sa | sb, a};
  endfunction
  // operand with signed zeros, infinities and nans mixed in
  function automatic logic [63:0] pick(input logic dl);
    int fw = dl ? `FCIM_DP_FRAC_W : `FCIM_SP_FRAC_W;
    logic [63:0] v = {$urandom, $urandom};
    logic [63:0] s = v & (64'h1 << (dl ? 63 : 31));
    if (!dl) v = v[31:0];
    case ($urandom_range(3))
      0: v = s;
      1: v = ((dl ? 64'h7FF : 64'hFF) << fw) | s;
      2: v = ((dl ? 64'h7FF : 64'hFF) << fw) | v | 64'h1;
      default: ;
    endcase
    return v;
  endfunction
  ////////////////////////////////////////
  // issue one op, resolve it if speculative, then check result and registers
  task automatic run(input fcim_issue_s i, input logic kill);
    logic [64:0] e = mm(i.op, i.dbl, i.opa, i.opb);
    logic mo = i.op inside {FCIM_OP_NUM_LO, FCIM_OP_NUM_HI, FCIM_OP_STR_LO, FCIM_OP_STR_HI};
    logic cvt = i.op inside {FCIM_OP_CVT_WIDE, FCIM_OP_CVT_LONG};
    logic trap;
    int n = 0;
    kill = kill & i.spec;
    trap = (mo & e[64] & !mask_q | cvt) & !kill;
    cpu.send(i);
    @(posedge ref_clk);
    if (i.spec) cpu.resolve(kill);
    do begin
      @(negedge ref_clk);
      n++;
    end while (result.valid !== 1'b1 && n < 40);
    check("result valid", result.valid, !kill);
    check("trap", fault_trap, trap);
    if (!kill) check("result dst", result.dst, i.dst);
    if (mo && !kill) check("data", i.dbl ? result.data : result.data[31:0], e[63:0]);
    if (trap) foa_q = i.addr;
    apb(1'b0, `FCIM_ADDR_FOA, 32'h0);
    check("fault address", rd, {8'h0, foa_q});
    apb(1'b0, `FCIM_ADDR_STAT, 32'h0);
    if (!cvt) check("bad op flag", rd[0], mo & e[64] & !kill);
    check("huge flag", rd[1], cvt);
    apb(1'b1, `FCIM_ADDR_STAT, 32'h3);
  endtask
  ////////////////////////////////////////
  initial begin
    mask_q = 1'b1;
    void'($urandom(32'h95D0));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, `FCIM_ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, `FCIM_CTRL_RESET);
    apb(1'b0, `FCIM_ADDR_FOA, 32'h0);
    check("address reset", rd, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    check("unmapped refused", err, 1'b1);
    // address register in normal and debug mode
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `FCIM_ADDR_CTRL, {30'h0, m[0], 1'b1});
      apb(1'b1, `FCIM_ADDR_FOA, 32'hFFA5_5A00 | m);
      apb(1'b0, `FCIM_ADDR_FOA, 32'h0);
      check("address rw", rd, 32'h00A5_5A00 | m);
    end
    apb(1'b1, `FCIM_ADDR_CTRL, `FCIM_CTRL_RESET);
    foa_q = 24'hA5_5A01;
    $display("test registers done");
    // random min/max, masked then unmasked
    for (int k = 0; k < 200; k++) begin
      if (k == 100) begin
        apb(1'b1, `FCIM_ADDR_CTRL, 32'h0);
        mask_q = 1'b0;
      end
      d = 1'($urandom_range(1));
      ins = {fcim_op_e'($urandom_range(4, 1)), d, 5'($urandom), pick(d), pick(d),
        24'($urandom), $urandom_range(7) == 0};
      run(ins, 1'($urandom_range(1)));
    end
    $display("test min max done");
    // hazard on a pending divide, then a long and a wide conversion
    ins = {FCIM_OP_DIV, 1'b0, 5'h5, 64'h3F80_0000, 64'h4000_0000, 24'h00_0042, 1'b0};
    cpu.send(ins);
    cpu.probe(5'h5, 1'b1);
    @(negedge ref_clk);
    check("hazard stall", issue_stall, 1'b1);
    cpu.probe(5'h6, 1'b1);
    @(negedge ref_clk);
    check("no hazard", issue_stall, 1'b0);
    cpu.probe(5'h6, 1'b0);
    ins.op = FCIM_OP_CVT_LONG;
    ins.opa = 64'h7149_F2CA;
    run(ins, 1'b0);
    ins = {FCIM_OP_CVT_WIDE, 1'b1, 5'h7, 64'h7E37_E43C_8800_759C, 64'h0, 24'h00_0077, 1'b0};
    run(ins, 1'b0);
    // long execute and plain move through the full pipeline
    ins.op = FCIM_OP_DIV;
    run(ins, 1'b0);
    ins.op = FCIM_OP_MOVE;
    run(ins, 1'b0);
    $display("test hazard convert done");
    stop_test();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
